/* File: hw/disk_layout_pkg.sv */
/*
 Constants, types and field layout for the disk sector layout mapper.
 Assumes one byte clock enable from the read/write channel.
*/
// ==========================================================
// Summary of operation
// R1 - Cylinder holds 34 hard sectors per head
// R2 - Every track carries exactly 34 fixed sectors
// R3 - Block length change keeps sector positions
// R4 - Last cylinder sectors are spares, 0..34
// R5 - Alternate cylinders programmable 0..8, default 2
// R6 - Skew values fixed; skew writes ignored
// R7 - Track skew 12 sectors, 16 on small
// R8 - Cylinder skew 16 sectors, 24 on small
// R9 - Format skips bad sectors, shifting later blocks
// R10 - Exhausted spares spill into alternate cylinders
// R11 - Reassign uses own cylinder spare first
// R12 - Reassign replaces in place, no skip
// R13 - Only 256 and 512 byte formats
// R14 - 256 mode: two fields, even then odd
// R15 - 256 mode reassign moves the partner block
// R16 - Adjust steps 2 bytes, 1 for 1024
// R17 - First gap: splice plus nine sync bytes
// R18 - Data gaps: 13 then 16 bytes
// R19 - Data field: mark 19h, data, ECC
// R20 - Servo zone 30 bytes inhibits read/write
// R21 - System area rejects all host access
// R22 - Diagnostic area reached by long commands only
// R23 - Diagnostic addresses start at 80000000h
package disk_layout_pkg;
	// Geometry
	localparam logic [8:0] SLOTS_PER_TRK = 9'h022;
	localparam logic [5:0] MAX_SPARES = 6'h22;
	localparam logic [5:0] DEF_SPARES = 6'h05;
	localparam logic [3:0] MAX_ALTCYL = 4'h8;
	localparam logic [3:0] DEF_ALTCYL = 4'h2;
	localparam logic [15:0] USER_CYLS = 16'h0200;
	localparam logic [2:0] TBL_DEPTH = 3'h4;
	// Skews in sectors
	localparam logic [5:0] TRK_SKEW = 6'h0C;
	localparam logic [5:0] TRK_SKEW_SMALL = 6'h10;
	localparam logic [5:0] CYL_SKEW = 6'h10;
	localparam logic [5:0] CYL_SKEW_SMALL = 6'h18;
	// Addressing
	localparam logic [31:0] DIAG_BASE = 32'h8000_0000;
	localparam logic signed [31:0] ADJ_LIMIT = 32'sh0000_0014;
	localparam logic [7:0] SYNC_MARK = 8'h19;
	// Byte offsets inside one sector
	localparam logic [9:0] G1_END = 10'h00A;
	localparam logic [9:0] ID_END = 10'h014;
	localparam logic [9:0] MARK1_POS = 10'h021;
	localparam logic [9:0] ECC1_POS = 10'h122;
	localparam logic [9:0] D1_END = 10'h129;
	localparam logic [9:0] MARK2_POS = 10'h139;
	localparam logic [9:0] ECC2_POS = 10'h23A;
	localparam logic [9:0] D2_END = 10'h241;
	localparam logic [9:0] ECC_512_POS = 10'h222;
	localparam logic [9:0] D_512_END = 10'h229;
	localparam logic [9:0] SERVO_POS = 10'h25A;
	localparam logic [9:0] SEC_LAST = 10'h277;
	// Register indices
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_SPARES = 4'h1;
	localparam logic [3:0] REG_ALTCYL = 4'h2;
	localparam logic [3:0] REG_SKEW = 4'h3;
	localparam logic [3:0] REG_ADJUST = 4'h4;
	localparam logic [3:0] REG_LBA = 4'h5;
	localparam logic [3:0] REG_CMD = 4'h6;
	localparam logic [3:0] REG_DEFECT = 4'h7;
	localparam logic [3:0] REG_RESULT = 4'h8;
	localparam logic [3:0] REG_STATUS = 4'h9;
	localparam logic [3:0] CTRL_RESET = 4'h3;
	// Types
	typedef enum logic [2:0] {F_GAP, F_ID, F_MARK, F_DATA, F_ECC, F_SERVO} field_t;
	typedef struct packed {
		logic blk1024;
		logic fmt256;
		logic [1:0] variant;
	} ctrl_t;
	typedef struct packed {
		logic alt;
		logic [15:0] cyl;
		logic [8:0] slot;
	} loc_t;
	typedef struct packed {
		logic alt;
		logic half;
		logic [2:0] head;
		logic [5:0] rot;
		logic [15:0] cyl;
	} map_result_t;
endpackage

/* File: hw/disk_sector_layout_mapper.sv */
/*
 Sector layout mapper: block address to physical location, defect
 skipping, reassignment and the per-byte sector field sequencer.
 Assumes byte_tick_in and index_in are synchronous to ref_clk_in.
*/
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/10ps
`default_nettype none
module disk_sector_layout_mapper import disk_layout_pkg::*; (
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_in,
	// Register port
	input wire logic [3:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [31:0] reg_rdata_out,
	// Read/write channel
	input wire logic byte_tick_in,
	input wire logic index_in,
	output field_t field_out,
	output logic [7:0] mark_byte_out,
	output logic rw_inhibit_out,
	output logic sector_pulse_out,
	output logic [5:0] slot_out
);
	// ==========================================================
	// Helpers
	function automatic logic [5:0] mod34(input logic [7:0] v);
		logic [7:0] t;
		t = v;
		for (int i = 0; i < 7; i++) begin
			if (t >= 8'(SLOTS_PER_TRK)) begin
				t = t - 8'(SLOTS_PER_TRK);
			end
		end
		return t[5:0];
	endfunction

	function automatic logic [2:0] pop4(input logic [3:0] v);
		return 3'(v[0]) + 3'(v[1]) + 3'(v[2]) + 3'(v[3]);
	endfunction

	// ==========================================================
	// Configuration state
	ctrl_t ctrl_r, ctrl_nxt; // Variant and format
	logic [5:0] spares_r, spares_nxt; // Spares per cylinder
	logic [3:0] altcyl_r, altcyl_nxt; // Alternate cylinders
	logic [9:0] adj_r, adj_nxt; // Signed data length adjust
	logic [31:0] lba_r, lba_nxt; // Address under work
	logic [2:0] def_cnt_r, def_cnt_nxt; // Defect entries used
	logic def_we; // Append a defect entry
	logic signed [31:0] wsig; // Write data as signed
	logic cfg_wr; // Config write allowed
	logic [3:0] heads; // Heads of this variant
	logic [8:0] spc; // Sectors per cylinder
	logic [5:0] trk_skew; // Fixed track skew
	logic [5:0] cyl_skew; // Fixed cylinder skew
	logic [5:0] cyl_step; // Rotation gained per cylinder
	logic [9:0] bpc; // Blocks per cylinder
	logic [15:0] alt_base; // First alternate cylinder
	logic busy; // Mapper working

	// Derived geometry; skews hang only on the variant
	always_comb begin
		heads = {1'b0, ctrl_r.variant, 1'b0} + 4'h2;
		spc = 9'(heads) * SLOTS_PER_TRK; // R1 R2
		trk_skew = (ctrl_r.variant == 2'h0) ? TRK_SKEW_SMALL : TRK_SKEW; // R7
		cyl_skew = (ctrl_r.variant == 2'h0) ? CYL_SKEW_SMALL : CYL_SKEW; // R8
		cyl_step = mod34(8'(cyl_skew) + 8'(heads - 4'h1) * 8'(trk_skew)); // R8
		bpc = ctrl_r.fmt256 ? {spc - 9'(spares_r), 1'b0}
			: {1'b0, spc - 9'(spares_r)}; // R14
		alt_base = USER_CYLS - 16'(altcyl_r); // R5
	end

	// Register writes; changing layout mid-map would corrupt it
	always_comb begin
		ctrl_nxt = ctrl_r;
		spares_nxt = spares_r;
		altcyl_nxt = altcyl_r;
		adj_nxt = adj_r;
		lba_nxt = lba_r;
		def_cnt_nxt = def_cnt_r;
		def_we = 1'b0;
		wsig = $signed(reg_wdata_in);
		cfg_wr = reg_wr_in && !busy;
		if (cfg_wr) begin
			unique case (reg_addr_in)
				REG_CTRL: begin
					ctrl_nxt = ctrl_t'(reg_wdata_in[3:0]);
					// Sector slots never move; only block use changes
					if (ctrl_nxt.fmt256) begin // R3 R13
						ctrl_nxt.blk1024 = 1'b0;
						adj_nxt = 10'h000;
					end else if (!ctrl_nxt.blk1024) begin // R16
						// Back to 512 blocks: round down to an even step
						adj_nxt = {adj_r[9:1], 1'b0};
					end
				end
				REG_SPARES: begin
					if (reg_wdata_in <= 32'(MAX_SPARES)) begin // R4
						spares_nxt = reg_wdata_in[5:0];
					end
				end
				REG_ALTCYL: begin
					if (reg_wdata_in <= 32'(MAX_ALTCYL)) begin // R5
						altcyl_nxt = reg_wdata_in[3:0];
					end
				end
				REG_ADJUST: begin
					// Odd steps only with 1024-byte blocks
					if (!ctrl_r.fmt256 && wsig <= ADJ_LIMIT &&
						wsig >= -ADJ_LIMIT &&
						(ctrl_r.blk1024 || !reg_wdata_in[0])) begin // R13 R16
						adj_nxt = reg_wdata_in[9:0];
					end
				end
				REG_LBA: begin
					lba_nxt = reg_wdata_in;
				end
				REG_DEFECT: begin
					if (def_cnt_r < TBL_DEPTH) begin // R9
						def_we = 1'b1;
						def_cnt_nxt = def_cnt_r + 3'h1;
					end
				end
				default: begin
					// Skew and read-only writes are dropped
				end // R6
			endcase
		end
	end

	// Configuration registers
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			ctrl_r <= ctrl_t'(CTRL_RESET);
			spares_r <= DEF_SPARES;
			altcyl_r <= DEF_ALTCYL;
			adj_r <= 10'h000;
			lba_r <= 32'h0000_0000;
			def_cnt_r <= 3'h0;
		end else begin
			ctrl_r <= ctrl_nxt;
			spares_r <= spares_nxt;
			altcyl_r <= altcyl_nxt;
			adj_r <= adj_nxt;
			lba_r <= lba_nxt;
			def_cnt_r <= def_cnt_nxt;
		end
	end

	// ==========================================================
	// Defect and reassign tables
	loc_t def_tbl [4]; // Format-skipped slots
	logic [31:0] ra_key [4]; // Reassigned block units
	loc_t ra_dst [4]; // Their destinations
	logic ra_we; // Append reassign entry
	loc_t ra_loc; // Entry destination
	logic [2:0] ra_cnt_r, ra_cnt_nxt; // Reassign entries used
	logic [3:0] d_cyl_m, d_le_m, r_cyl_m, r_key_m;
	logic [15:0] cyl_r, cyl_nxt;
	logic [8:0] slot_r, slot_nxt;
	logic [31:0] key_r, key_nxt;

	// Per-entry matching
	for (genvar i = 0; i < 4; i++) begin : g_ent
		assign d_cyl_m[i] = (3'(i) < def_cnt_r) && !def_tbl[i].alt &&
			def_tbl[i].cyl == cyl_r;
		assign d_le_m[i] = d_cyl_m[i] && def_tbl[i].slot <= slot_r;
		assign r_cyl_m[i] = (3'(i) < ra_cnt_r) && !ra_dst[i].alt &&
			ra_dst[i].cyl == cyl_r;
		assign r_key_m[i] = (3'(i) < ra_cnt_r) && ra_key[i] == key_r;
	end

	// Table storage; entries are only ever appended
	always_ff @(posedge ref_clk_in) begin
		if (def_we) begin
			def_tbl[def_cnt_r[1:0]] <= {1'b0, reg_wdata_in[31:16],
				reg_wdata_in[8:0]};
		end
		if (ra_we) begin
			ra_key[ra_cnt_r[1:0]] <= key_r;
			ra_dst[ra_cnt_r[1:0]] <= ra_loc;
		end
	end

	// ==========================================================
	// Mapper state machine
	typedef enum logic [2:0] {M_IDLE, M_CYL, M_SKIP, M_RA, M_HEAD} map_st_t;
	map_st_t st_r, st_nxt;
	logic [31:0] rem_r, rem_nxt; // Blocks left to place
	logic [5:0] acc_r, acc_nxt; // Rotation from skews
	logic [8:0] base_r, base_nxt; // Slot before skipping
	logic [1:0] it_r, it_nxt; // Skip iteration
	logic [2:0] head_r, head_nxt;
	logic half_r, half_nxt, alt_r, alt_nxt, ra_r, ra_nxt;
	logic done_r, done_nxt, rej_r, rej_nxt, pcopy_r, pcopy_nxt;
	logic altused_r, altused_nxt;
	logic [8:0] altnext_r, altnext_nxt; // Next alternate slot
	map_result_t res_r, res_nxt;
	logic cmd_wr; // Command register write
	logic [3:0] hit; // Reassign hit vector
	logic [6:0] used; // Spares consumed in cylinder

	assign busy = (st_r != M_IDLE);
	assign cmd_wr = reg_wr_in && reg_addr_in == REG_CMD;

	// Next state of the mapper
	always_comb begin
		st_nxt = st_r;
		rem_nxt = rem_r;
		cyl_nxt = cyl_r;
		acc_nxt = acc_r;
		base_nxt = base_r;
		slot_nxt = slot_r;
		it_nxt = it_r;
		head_nxt = head_r;
		half_nxt = half_r;
		alt_nxt = alt_r;
		ra_nxt = ra_r;
		key_nxt = key_r;
		done_nxt = done_r;
		rej_nxt = rej_r;
		pcopy_nxt = pcopy_r;
		altused_nxt = altused_r;
		altnext_nxt = altnext_r;
		res_nxt = res_r;
		ra_cnt_nxt = ra_cnt_r;
		ra_we = 1'b0;
		ra_loc = '0;
		hit = r_key_m;
		used = 7'(pop4(d_cyl_m)) + 7'(pop4(r_cyl_m));
		unique case (st_r)
			M_IDLE: begin
				if (cmd_wr) begin
					done_nxt = 1'b0;
					rej_nxt = 1'b0;
					pcopy_nxt = 1'b0;
					if (reg_wdata_in[3]) begin
						rej_nxt = 1'b1; // R21
					end else if (lba_r[31] && !reg_wdata_in[2]) begin
						rej_nxt = 1'b1; // R22 R23
					end else if (reg_wdata_in[1] && ra_cnt_r == TBL_DEPTH) begin
						rej_nxt = 1'b1;
					end else if (reg_wdata_in[1] || reg_wdata_in[0]) begin
						rem_nxt = lba_r[31] ? lba_r - DIAG_BASE : lba_r; // R23
						cyl_nxt = lba_r[31] ? USER_CYLS : 16'h0000;
						acc_nxt = 6'h00;
						head_nxt = 3'h0;
						alt_nxt = 1'b0;
						// Both blocks of a sector share one key
						key_nxt = ctrl_r.fmt256 ? {1'b0, lba_r[31:1]} : lba_r; // R15
						ra_nxt = reg_wdata_in[1];
						st_nxt = M_CYL;
					end
				end
			end
			M_CYL: begin
				// Repeated subtraction: slow but small
				if (rem_r >= 32'(bpc)) begin
					rem_nxt = rem_r - 32'(bpc);
					cyl_nxt = cyl_r + 16'h0001;
					acc_nxt = mod34(8'(acc_r) + 8'(cyl_step)); // R8
				end else begin
					base_nxt = ctrl_r.fmt256 ? rem_r[9:1] : rem_r[8:0];
					slot_nxt = base_nxt;
					half_nxt = ctrl_r.fmt256 && rem_r[0]; // R14
					it_nxt = 2'h0;
					st_nxt = M_SKIP;
				end
			end
			M_SKIP: begin
				// Four passes reach the fixed point of four entries
				slot_nxt = base_r + 9'(pop4(d_le_m)); // R9
				it_nxt = it_r + 2'h1;
				if (it_r == 2'h3) begin
					if (slot_nxt >= spc) begin
						alt_nxt = 1'b1; // R10
						altused_nxt = 1'b1;
						cyl_nxt = alt_base;
						slot_nxt = slot_nxt - spc;
					end
					st_nxt = ra_r ? M_RA : M_HEAD;
					for (int i = 0; i < 4; i++) begin
						if (!ra_r && hit[i]) begin
							alt_nxt = ra_dst[i].alt; // R12
							cyl_nxt = ra_dst[i].cyl;
							slot_nxt = ra_dst[i].slot;
						end
					end
				end
			end
			M_RA: begin
				if (used < 7'(spares_r)) begin
					ra_loc = {1'b0, cyl_r, spc - 9'(spares_r) + 9'(used)}; // R11
				end else begin
					ra_loc = {1'b1, alt_base, altnext_r}; // R11
					altnext_nxt = altnext_r + 9'h001;
					altused_nxt = 1'b1;
				end
				// Only the table changes; no later block shifts
				ra_we = 1'b1; // R12
				ra_cnt_nxt = ra_cnt_r + 3'h1;
				pcopy_nxt = ctrl_r.fmt256; // R15
				alt_nxt = ra_loc.alt;
				cyl_nxt = ra_loc.cyl;
				slot_nxt = ra_loc.slot;
				st_nxt = M_HEAD;
			end
			M_HEAD: begin
				if (slot_r >= SLOTS_PER_TRK) begin
					slot_nxt = slot_r - SLOTS_PER_TRK;
					head_nxt = head_r + 3'h1;
				end else begin
					res_nxt.alt = alt_r;
					res_nxt.half = half_r;
					res_nxt.head = head_r;
					res_nxt.cyl = cyl_r;
					res_nxt.rot = mod34(8'(slot_r) + 8'(acc_r) +
						8'(head_r) * 8'(trk_skew)); // R7
					done_nxt = 1'b1;
					st_nxt = M_IDLE;
				end
			end
		endcase
	end

	// Mapper registers
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			st_r <= M_IDLE;
			rem_r <= 32'h0000_0000;
			cyl_r <= 16'h0000;
			acc_r <= 6'h00;
			base_r <= 9'h000;
			slot_r <= 9'h000;
			it_r <= 2'h0;
			head_r <= 3'h0;
			half_r <= 1'b0;
			alt_r <= 1'b0;
			ra_r <= 1'b0;
			key_r <= 32'h0000_0000;
			done_r <= 1'b0;
			rej_r <= 1'b0;
			pcopy_r <= 1'b0;
			altused_r <= 1'b0;
			altnext_r <= 9'h000;
			res_r <= '0;
			ra_cnt_r <= 3'h0;
		end else begin
			st_r <= st_nxt;
			rem_r <= rem_nxt;
			cyl_r <= cyl_nxt;
			acc_r <= acc_nxt;
			base_r <= base_nxt;
			slot_r <= slot_nxt;
			it_r <= it_nxt;
			head_r <= head_nxt;
			half_r <= half_nxt;
			alt_r <= alt_nxt;
			ra_r <= ra_nxt;
			key_r <= key_nxt;
			done_r <= done_nxt;
			rej_r <= rej_nxt;
			pcopy_r <= pcopy_nxt;
			altused_r <= altused_nxt;
			altnext_r <= altnext_nxt;
			res_r <= res_nxt;
			ra_cnt_r <= ra_cnt_nxt;
		end
	end

	// ==========================================================
	// Register read port, data one cycle after the strobe
	logic [31:0] rdata_nxt;

	always_comb begin
		rdata_nxt = 32'h0000_0000;
		if (reg_rd_in) begin
			unique case (reg_addr_in)
				REG_CTRL: rdata_nxt = {28'h0000000, ctrl_r};
				REG_SPARES: rdata_nxt = {26'h0000000, spares_r};
				REG_ALTCYL: rdata_nxt = {28'h0000000, altcyl_r};
				REG_SKEW: rdata_nxt = {20'h00000, cyl_skew, trk_skew};
				REG_ADJUST: rdata_nxt = {{22{adj_r[9]}}, adj_r};
				REG_LBA: rdata_nxt = lba_r;
				REG_DEFECT: rdata_nxt = {29'h00000000, def_cnt_r};
				REG_RESULT: rdata_nxt = {5'h00, res_r};
				REG_STATUS: rdata_nxt = {21'h000000, ra_cnt_r, def_cnt_r,
					altused_r, pcopy_r, rej_r, done_r, busy};
				default: rdata_nxt = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			reg_rdata_out <= 32'h0000_0000;
		end else begin
			reg_rdata_out <= rdata_nxt;
		end
	end

	// ==========================================================
	// Sector field sequencer, one step per channel byte
	logic [9:0] pos_r, pos_nxt; // Byte inside sector
	logic [5:0] slot_nxt_q; // Next slot on track
	logic pulse_nxt;
	field_t fld_nxt;
	logic [9:0] ecc_pos, d_end; // Adjusted 512 bounds

	always_comb begin
		pos_nxt = pos_r;
		slot_nxt_q = slot_out;
		pulse_nxt = 1'b0;
		ecc_pos = 10'(ECC_512_POS + adj_r); // R16
		d_end = 10'(D_512_END + adj_r);
		if (index_in) begin
			pos_nxt = 10'h000;
			slot_nxt_q = 6'h00;
		end else if (byte_tick_in) begin
			if (pos_r == SEC_LAST) begin
				pos_nxt = 10'h000;
				pulse_nxt = 1'b1;
				// Slot count per track never varies
				slot_nxt_q = (slot_out == 6'(SLOTS_PER_TRK - 9'h001)) ?
					6'h00 : slot_out + 6'h01; // R2
			end else begin
				pos_nxt = pos_r + 10'h001;
			end
		end
		// Field map of the byte being entered
		if (pos_nxt < G1_END) fld_nxt = F_GAP; // R17
		else if (pos_nxt < ID_END) fld_nxt = F_ID;
		else if (pos_nxt < MARK1_POS) fld_nxt = F_GAP; // R18
		else if (pos_nxt == MARK1_POS) fld_nxt = F_MARK; // R19
		else if (pos_nxt >= SERVO_POS) fld_nxt = F_SERVO; // R20
		else if (ctrl_r.fmt256) begin // R14
			if (pos_nxt < ECC1_POS) fld_nxt = F_DATA;
			else if (pos_nxt < D1_END) fld_nxt = F_ECC;
			else if (pos_nxt < MARK2_POS) fld_nxt = F_GAP; // R18
			else if (pos_nxt == MARK2_POS) fld_nxt = F_MARK;
			else if (pos_nxt < ECC2_POS) fld_nxt = F_DATA;
			else if (pos_nxt < D2_END) fld_nxt = F_ECC;
			else fld_nxt = F_GAP;
		end else begin
			if (pos_nxt < ecc_pos) fld_nxt = F_DATA;
			else if (pos_nxt < d_end) fld_nxt = F_ECC;
			else fld_nxt = F_GAP;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			pos_r <= 10'h000;
			slot_out <= 6'h00;
			sector_pulse_out <= 1'b0;
			field_out <= F_GAP;
			mark_byte_out <= 8'h00;
			rw_inhibit_out <= 1'b0;
		end else begin
			pos_r <= pos_nxt;
			slot_out <= slot_nxt_q;
			sector_pulse_out <= pulse_nxt;
			field_out <= fld_nxt;
			mark_byte_out <= (fld_nxt == F_MARK) ? SYNC_MARK : 8'h00;
			rw_inhibit_out <= (fld_nxt == F_SERVO);
		end
	end

	// ==========================================================
	// Checks
	chk_spare_range: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R4
		spares_r <= MAX_SPARES) else $error("spare count out of range");
	chk_altcyl_range: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R5
		altcyl_r <= MAX_ALTCYL) else $error("alternate cylinders out of range");
	chk_skew_write: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R6
		reg_wr_in && reg_addr_in == REG_SKEW |=> $stable(ctrl_r) && $stable(spares_r))
		else $error("skew write changed state");
	chk_adj_step: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R16
		!ctrl_r.blk1024 |-> !adj_r[0]) else $error("odd adjust on 512 blocks");
	chk_gap1_field: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R17
		$past(byte_tick_in) && !$past(index_in) && pos_r < G1_END |-> field_out == F_GAP)
		else $error("first gap field wrong");
	chk_mark_value: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R19
		field_out == F_MARK |-> mark_byte_out == 8'h19) else $error("bad sync mark");
	chk_servo_inhibit: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R20
		pos_r >= SERVO_POS |-> rw_inhibit_out && field_out == F_SERVO)
		else $error("servo zone not inhibited");
	chk_system_reject: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R21
		st_r == M_IDLE && cmd_wr && reg_wdata_in[3] |=> rej_r && st_r == M_IDLE)
		else $error("system area access not rejected");
	chk_diag_short: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R22
		st_r == M_IDLE && cmd_wr && lba_r[31] && !reg_wdata_in[2] && !reg_wdata_in[3]
		|=> rej_r) else $error("short command reached diagnostic area");
	chk_slot_wrap: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R2
		slot_out < 6'h22) else $error("slot beyond track");
endmodule
`default_nettype wire

/* File: verif/media_channel_model.sv */
/*
 Read/write channel stand-in: one index pulse, then a byte tick every
 four clocks while run_in stays high.
 Assumes run_in is held for whole passes and dropped between them.
*/
`timescale 1ns/10ps
`default_nettype none
module media_channel_model (
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_in,
	// Pass control
	input wire logic run_in,
	// Channel strobes
	output logic byte_tick_out,
	output logic index_out
);
	logic [1:0] div_r; // Tick divider
	logic run_r; // Delayed run, finds the start edge
	// ==========================================================
	// Strobes
	// Ticks sit four clocks apart so outputs settle between bytes
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			run_r <= 1'b0;
			div_r <= 2'h0;
			index_out <= 1'b0;
			byte_tick_out <= 1'b0;
		end else begin
			run_r <= run_in;
			index_out <= run_in & ~run_r;
			div_r <= run_r ? div_r + 2'h1 : 2'h0;
			byte_tick_out <= run_r & (div_r == 2'h3);
		end
	end
endmodule
`default_nettype wire

/* File: verif/tb_disk_sector_layout_mapper.sv */
/*
 Self-checking bench for the sector layout mapper.
 Assumes the register port answers one cycle after a read strobe.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_disk_sector_layout_mapper import disk_layout_pkg::*;;
	logic clk, rst, wr_s, rd_s, run, tick, idx, pulse, inh;
	logic [3:0] addr; // Register index
	logic [31:0] wd, rdata, st, res; // Bus data and results
	logic [7:0] mark;
	logic [5:0] slot;
	field_t fld;
	int bad_count, check_count, pulses;
	disk_sector_layout_mapper dut (.ref_clk_in(clk), .rst_in(rst),
		.reg_addr_in(addr), .reg_wdata_in(wd), .reg_wr_in(wr_s),
		.reg_rd_in(rd_s), .reg_rdata_out(rdata), .byte_tick_in(tick),
		.index_in(idx), .field_out(fld), .mark_byte_out(mark),
		.rw_inhibit_out(inh), .sector_pulse_out(pulse), .slot_out(slot));
	media_channel_model chan (.ref_clk_in(clk), .rst_in(rst),
		.run_in(run), .byte_tick_out(tick), .index_out(idx));
	// ==========================================================
	// Clock, pulse counter, watchdog
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) begin
		if (pulse === 1'b1) pulses <= pulses + 1;
	end
	// Whole run needs about 6000 cycles
	initial begin
		repeat (60000) @(posedge clk);
		bad_count++;
		results();
	end
	// ==========================================================
	// Shared tasks
	task automatic results();
		if (bad_count == 0 && check_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	// Bus tasks start just after a rising edge and end on one
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		addr <= a;
		wd <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
		// One idle edge so the strobe drops low before a following write raises it
		@(posedge clk);
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] v);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1 v = rdata;
		@(posedge clk);
	endtask
	// Write then read back against the expected contents
	task automatic wrc(input logic [3:0] a, input logic [31:0] d, input logic [31:0] e);
		logic [31:0] v;
		wr(a, d);
		rd(a, v);
		chk("register", e, v);
	endtask
	task automatic do_reset();
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
	endtask
	// Issue a command and poll until done or reject, bounded
	task automatic map(input logic [31:0] lba, input logic [31:0] cmd);
		int n;
		wr(REG_LBA, lba);
		wr(REG_CMD, cmd);
		st = 32'h0;
		for (n = 0; n < 300 && st[2:1] == 2'b00; n++) rd(REG_STATUS, st);
		rd(REG_RESULT, res);
	endtask
	function automatic field_t exp_field(input int p, input logic f);
		if (p < 10 || (p >= 20 && p < 33)) return F_GAP;
		if (p < 20) return F_ID;
		if (p == 33 || (f && p == 313)) return F_MARK;
		if (p >= 602) return F_SERVO;
		if (f && (p < 290 || (p >= 314 && p < 570))) return F_DATA;
		if (f && (p < 297 || (p >= 570 && p < 577))) return F_ECC;
		if (f || p >= 553) return F_GAP;
		return (p < 546) ? F_DATA : F_ECC;
	endfunction
	// ==========================================================
	// Scenarios
	task automatic regs_and_limits();
		wrc(REG_CTRL, 32'h3, 32'h3);
		wrc(REG_ALTCYL, 32'h2, 32'h2);
		wrc(REG_SKEW, 32'h0, 32'h40C);
		wrc(REG_CTRL, 32'h0, 32'h0);
		wrc(REG_SKEW, 32'hFFF, 32'h610);
		wrc(REG_SPARES, 32'h22, 32'h22);
		wrc(REG_SPARES, 32'h23, 32'h22);
		wrc(REG_ALTCYL, 32'h9, 32'h2);
		wrc(REG_ALTCYL, 32'h8, 32'h8);
		wrc(REG_ADJUST, 32'h3, 32'h0);
		wrc(REG_ADJUST, 32'hFFFFFFEC, 32'hFFFFFFEC);
		wrc(REG_ADJUST, 32'h15, 32'hFFFFFFEC);
		wrc(REG_CTRL, 32'hB, 32'hB);
		wrc(REG_ADJUST, 32'h3, 32'h3);
		wrc(REG_CTRL, 32'h3, 32'h3);
		rd(REG_ADJUST, st);
		chk("adjust", 32'h2, st);
		wrc(REG_CTRL, 32'h7, 32'h7);
		wrc(REG_ADJUST, 32'h4, 32'h0);
	endtask
	// One sector plus the wrap, checked byte by byte
	task automatic seq_pass(input logic f);
		int p;
		int p0;
		field_t e;
		run <= 1'b1;
		@(posedge clk iff idx);
		p0 = pulses;
		for (p = 0; p < 633; p++) begin
			if (p > 0) @(posedge clk iff tick);
			repeat (2) @(posedge clk);
			#1 e = exp_field(p % 632, f);
			chk("field", 32'(e), 32'(fld));
			chk("mark", (e == F_MARK) ? 32'h19 : 32'h0, 32'(mark));
			chk("inhibit", 32'(e == F_SERVO), 32'(inh));
		end
		chk("pulses", 32'h1, 32'(pulses - p0));
		chk("slot", 32'h1, 32'(slot));
		run <= 1'b0;
		@(posedge clk);
	endtask
	task automatic mapping();
		map(32'h0, 32'h1);
		chk("result", 32'h0, res);
		map(32'd34, 32'h1);
		chk("result", 32'h004C0000, res);
		map(32'd267, 32'h1);
		chk("result", 32'h00200001, res);
		map(32'h80000000, 32'h5);
		chk("result", 32'h00000200, res);
		map(32'h80000000, 32'h1);
		chk("status", 32'h4, st & 32'h6);
		map(32'h0, 32'h9);
		chk("status", 32'h4, st & 32'h6);
		wr(REG_CTRL, 32'h7);
		map(32'h1, 32'h1);
		chk("result", 32'h02000000, res);
	endtask
	task automatic defects();
		wr(REG_DEFECT, 32'h0);
		map(32'h0, 32'h1);
		chk("result", 32'h00010000, res);
		rd(REG_DEFECT, st);
		chk("defects", 32'h1, st);
		wr(REG_SPARES, 32'h0);
		map(32'd271, 32'h1);
		chk("result", 32'h040001FE, res);
	endtask
	task automatic reassign();
		map(32'd5, 32'h2);
		chk("result", 32'h01CB0000, res);
		map(32'd6, 32'h1);
		chk("result", 32'h00060000, res);
		map(32'd5, 32'h1);
		chk("result", 32'h01CB0000, res);
		wr(REG_SPARES, 32'h0);
		map(32'd9, 32'h2);
		chk("result", 32'h040001FE, res & 32'h0400FFFF);
		wr(REG_CTRL, 32'h7);
		map(32'd7, 32'h2);
		chk("result", 32'h060101FE, res);
		chk("status", 32'h8, st & 32'h8);
		map(32'd6, 32'h1);
		chk("result", 32'h040101FE, res);
	endtask
	// ==========================================================
	// Main sequence
	initial begin
		rst = 1'b1;
		addr = 4'h0;
		wd = 32'h0;
		wr_s = 1'b0;
		rd_s = 1'b0;
		run = 1'b0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		regs_and_limits();
		do_reset();
		seq_pass(1'b0);
		wr(REG_CTRL, 32'h7);
		seq_pass(1'b1);
		do_reset();
		mapping();
		do_reset();
		defects();
		do_reset();
		reassign();
		results();
	end
endmodule
`default_nettype wire
